// [src/stq_trigger_qualifier.sv]
// Trigger qualifier: modes, Boolean and time-qualified triggering, APB registers
//
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module stq_trigger_qualifier
    import stq_pkg::*;
#(
    parameter int TW = 16,
    parameter int LW = 8,
    parameter int AUTO_WAIT_CYC = 10000
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cmp_a,
    input wire logic cmp_b,
    input wire logic cmp_w,
    input wire logic [LW-1:0] sig_max,
    input wire logic [LW-1:0] sig_min,
    output logic main_trig,
    output logic win_trig,
    output logic acq_run,
    output logic free_run,
    output logic bw_limit,
    output logic [LW-1:0] trig_level
);
    localparam int GC = GLITCH_CYC;
    localparam logic [3:0] GC4 = 4'(GLITCH_CYC);

    // Qualifier test on a measured count
    function automatic logic qual_ok(input logic [2:0] q, input logic [TW-1:0] v,
                                     input logic [TW-1:0] l1, input logic [TW-1:0] l2);
        logic r;
        r = 1'b0;
        case (q)
            Q_LT1: r = (v < l1);
            Q_GT1: r = (v > l1);
            Q_INSIDE: r = (v > l1) && (v < l2);
            Q_OUTSIDE: r = (v < l1) || (v > l2);
            default: r = 1'b1;
        endcase
        return r;
    endfunction : qual_ok

    // Reset release through two flip-flops
    logic rs1_reg;
    logic rst_n;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rs1_reg <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rs1_reg <= 1'b1;
            rst_n <= rs1_reg;
        end
    end

    logic [31:0] ctrl_reg;
    stq_expr_t expr_reg;
    logic [TW-1:0] t1_reg;
    logic [TW-1:0] t2_reg;
    logic [LW-1:0] lvl_req_reg;
    logic lvl_user_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;

    wire [1:0] mode = ctrl_reg[1:0];
    wire [2:0] cpl = ctrl_reg[CPL_LSB+2:CPL_LSB];
    wire slope_pos = ctrl_reg[SLOPE_BIT];

    // Bus decode
    wire access = psel && penable && !pready_reg;
    wire wr = access && pwrite;
    wire hit_ctrl = (paddr == OFS_CTRL);
    wire hit_expr = (paddr == OFS_EXPR);
    wire hit_t1 = (paddr == OFS_TIME1);
    wire hit_t2 = (paddr == OFS_TIME2);
    wire hit_lvl = (paddr == OFS_LEVEL);
    wire hit_st = (paddr == OFS_STATUS);
    wire mapped = hit_ctrl || hit_expr || hit_t1 || hit_t2 || hit_lvl || hit_st;

    stq_expr_t new_expr;
    assign new_expr = stq_expr_t'(pwdata[$bits(stq_expr_t)-1:0]);
    wire new_bin = (new_expr.op == OP_AND) || (new_expr.op == OP_OR)
        || (new_expr.op == OP_XOR);
    wire new_ext = new_bin || (new_expr.op == OP_TO) || new_expr.inv_a || new_expr.inv_b
        || (new_expr.qual != Q_NONE) || new_expr.lvl_qual;
    wire new_range = (new_expr.qual == Q_INSIDE) || (new_expr.qual == Q_OUTSIDE)
        || (new_expr.win_qual == Q_INSIDE) || (new_expr.win_qual == Q_OUTSIDE);
    wire both_timed = (new_expr.qual != Q_NONE) && (new_expr.win_qual != Q_NONE);
    wire expr_bad = (new_bin && (new_expr.win_en || new_expr.lvl_qual))
        || (new_expr.op == OP_TO && new_expr.win_en)
        || both_timed
        || (new_range && both_timed)
        || (!new_expr.win_en && new_expr.win_qual != Q_NONE);
    wire wr_err = wr && (!mapped || hit_st || (hit_expr && expr_bad));

    wire bin = (expr_reg.op == OP_AND) || (expr_reg.op == OP_OR) || (expr_reg.op == OP_XOR);
    wire ext = bin || (expr_reg.op == OP_TO) || expr_reg.inv_a || expr_reg.inv_b
        || (expr_reg.qual != Q_NONE) || expr_reg.lvl_qual;

    // Extended settings forced into the allowed set
    function automatic logic [31:0] coerce(input logic [31:0] c);
        logic [31:0] r;
        r = c;
        if (r[CPL_LSB+2:CPL_LSB] > CPL_DC_HFR) begin
            r[CPL_LSB+2:CPL_LSB] = CPL_DC;
        end
        r[SLOPE_BIT] = 1'b1;
        if (r[1:0] != MODE_NORMAL) begin
            r[1:0] = MODE_AUTO;
        end
        return r;
    endfunction : coerce

    wire [31:0] ctrl_w = {23'h00_0000, pwdata[SLOPE_BIT:0]};
    wire [31:0] ctrl_fix = (mode == MODE_AUTO_LEVEL || mode == MODE_AUTO
        || mode == MODE_NORMAL) ? ctrl_reg : CTRL_RST;
    wire [31:0] ctrl_next = (wr && hit_ctrl) ? (ext ? coerce(ctrl_w) : ctrl_w)
        : (wr && hit_expr && !expr_bad && new_ext) ? coerce(ctrl_reg) : ctrl_fix;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= CTRL_RST;
            expr_reg <= '0;
            t1_reg <= '0;
            t2_reg <= '0;
            lvl_req_reg <= '0;
            lvl_user_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            if (wr && hit_expr && !expr_bad) begin
                expr_reg <= new_expr;
            end
            if (wr && hit_t1) begin
                t1_reg <= pwdata[TW-1:0];
            end
            if (wr && hit_t2) begin
                t2_reg <= pwdata[TW-1:0];
            end
            if (wr && hit_lvl) begin
                lvl_req_reg <= pwdata[LW-1:0];
            end
            if (wr && hit_lvl) begin
                lvl_user_reg <= 1'b1;
            end else if (wr && hit_ctrl) begin
                lvl_user_reg <= 1'b0;
            end
        end
    end

    // Read mux
    logic [31:0] status_w;
    assign status_w = {16'h0000, trig_level, 5'h00, bw_limit, free_run, acq_run};
    wire [31:0] rd_w = hit_ctrl ? ctrl_reg
        : hit_expr ? 32'(expr_reg)
        : hit_t1 ? 32'(t1_reg)
        : hit_t2 ? 32'(t2_reg)
        : hit_lvl ? 32'(lvl_req_reg)
        : hit_st ? status_w : 32'h0000_0000;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            pready_reg <= access;
            pslverr_reg <= access && (wr_err || (!pwrite && !mapped));
            prdata_reg <= (access && !pwrite) ? rd_w : 32'h0000_0000;
        end
    end
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;

    // Source logic values, A and B each compared against its own level, the window source against the A level
    wire pol = !ext && !slope_pos;
    wire src_a = cmp_a ^ expr_reg.inv_a ^ pol;
    wire src_b = cmp_b ^ expr_reg.inv_b;
    wire func = (expr_reg.op == OP_AND) ? (src_a && src_b)
        : (expr_reg.op == OP_OR) ? (src_a || src_b)
        : (expr_reg.op == OP_XOR) ? (src_a ^ src_b) : src_a;

    logic func_d_reg;
    logic [3:0] lo_cnt_reg;
    logic [3:0] hi_cnt_reg;
    logic lo_ok_reg;
    logic [TW-1:0] dur_reg;
    logic srcb_d_reg;
    logic to_act_reg;
    logic [TW-1:0] iv_reg;
    logic wsrc_d_reg;
    logic [TW-1:0] wdur_reg;

    wire rise = func && !func_d_reg;
    wire fall = !func && func_d_reg;
    wire lo_ok_w = rise ? (lo_cnt_reg >= GC4) : lo_ok_reg;
    wire bool_evt = func && (hi_cnt_reg == GC4 - 4'h1) && lo_ok_w;
    wire b_rise = src_b && !srcb_d_reg;
    wire a_rise = src_a && !func_d_reg;
    wire to_evt = b_rise && to_act_reg && qual_ok(expr_reg.qual, iv_reg, t1_reg, t2_reg);
    wire time_evt = fall && qual_ok(expr_reg.qual, dur_reg, t1_reg, t2_reg);
    wire main_evt = (expr_reg.op == OP_TO) ? to_evt
        : (expr_reg.qual == Q_NONE) ? bool_evt : time_evt;

    wire wsrc = cmp_w ^ expr_reg.win_inv;
    wire wfall = !wsrc && wsrc_d_reg;
    wire wq_evt = (expr_reg.win_qual == Q_NONE) ? (wsrc && !wsrc_d_reg)
        : (wfall && qual_ok(expr_reg.win_qual, wdur_reg, t1_reg, t2_reg));
    wire win_evt = bin ? main_evt : (expr_reg.win_en && wq_evt);

    wire [TW-1:0] tmax = {TW{1'b1}};
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            func_d_reg <= 1'b0;
            lo_cnt_reg <= 4'h0;
            hi_cnt_reg <= 4'h0;
            lo_ok_reg <= 1'b0;
        end else begin
            func_d_reg <= func;
            lo_cnt_reg <= func ? 4'h0 : ((lo_cnt_reg < GC4) ? lo_cnt_reg + 4'h1 : lo_cnt_reg);
            hi_cnt_reg <= !func ? 4'h0 : ((hi_cnt_reg < GC4) ? hi_cnt_reg + 4'h1 : hi_cnt_reg);
            lo_ok_reg <= lo_ok_w;
        end
    end

    // Duration and interval counters on the sample clock
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dur_reg <= '0;
            srcb_d_reg <= 1'b0;
            to_act_reg <= 1'b0;
            iv_reg <= '0;
            wsrc_d_reg <= 1'b0;
            wdur_reg <= '0;
        end else begin
            dur_reg <= !func ? '0 : (dur_reg != tmax ? dur_reg + 1'b1 : dur_reg);
            srcb_d_reg <= src_b;
            if (a_rise) begin
                to_act_reg <= 1'b1;
                iv_reg <= TW'(1);
            end else if (b_rise) begin
                to_act_reg <= 1'b0;
            end else if (to_act_reg && iv_reg != tmax) begin
                iv_reg <= iv_reg + 1'b1;
            end
            wsrc_d_reg <= wsrc;
            wdur_reg <= !wsrc ? '0 : (wdur_reg != tmax ? wdur_reg + 1'b1 : wdur_reg);
        end
    end

    // Acquisition control
    localparam int CW = $clog2(AUTO_WAIT_CYC + 1);
    localparam logic [CW-1:0] WAIT_LIM = CW'(AUTO_WAIT_CYC);
    stq_acq_t acq_reg;
    stq_acq_t acq_next;
    logic [CW-1:0] tmo_reg;
    wire tmo = (tmo_reg == WAIT_LIM);

    always_comb begin
        acq_next = acq_reg;
        case (acq_reg)
            ACQ_WAIT: begin
                if (!main_evt && tmo) begin
                    acq_next = (mode == MODE_NORMAL) ? ACQ_HALT : ACQ_FREE;
                end
            end
            ACQ_FREE: begin
                if (main_evt || mode == MODE_NORMAL) begin
                    acq_next = main_evt ? ACQ_WAIT : ACQ_HALT;
                end
            end
            ACQ_HALT: begin
                if (main_evt) begin
                    acq_next = ACQ_WAIT;
                end else if (mode != MODE_NORMAL) begin
                    acq_next = ACQ_FREE;
                end
            end
            default: acq_next = ACQ_WAIT;
        endcase
    end

    // Level band for automatic level
    wire [LW-1:0] span = sig_max - sig_min;
    wire [LW-1:0] lvl_lo = sig_min + LW'((32'(span) * LVL_LO_PCT) / PCT_FULL);
    wire [LW-1:0] lvl_hi = sig_min + LW'((32'(span) * LVL_HI_PCT) / PCT_FULL);
    wire [LW-1:0] lvl_mid = sig_min + (span >> MID_SHIFT);
    wire [LW-1:0] lvl_clamp = (lvl_req_reg < lvl_lo) ? lvl_lo
        : (lvl_req_reg > lvl_hi) ? lvl_hi : lvl_req_reg;
    wire [LW-1:0] lvl_next = (mode != MODE_AUTO_LEVEL) ? lvl_req_reg
        : lvl_user_reg ? lvl_clamp : lvl_mid;

    logic main_trig_reg;
    logic win_trig_reg;
    logic acq_run_reg;
    logic free_run_reg;
    logic bw_limit_reg;
    logic [LW-1:0] trig_level_reg;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            acq_reg <= ACQ_WAIT;
            tmo_reg <= '0;
            main_trig_reg <= 1'b0;
            win_trig_reg <= 1'b0;
            acq_run_reg <= 1'b0;
            free_run_reg <= 1'b0;
            bw_limit_reg <= 1'b0;
            trig_level_reg <= '0;
        end else begin
            acq_reg <= acq_next;
            tmo_reg <= (main_evt || acq_reg != ACQ_WAIT) ? '0 : (tmo ? tmo_reg : tmo_reg + 1'b1);
            main_trig_reg <= main_evt;
            win_trig_reg <= win_evt;
            acq_run_reg <= (acq_next != ACQ_HALT);
            free_run_reg <= (acq_next == ACQ_FREE);
            bw_limit_reg <= ext;
            trig_level_reg <= lvl_next;
        end
    end
    assign main_trig = main_trig_reg;
    assign win_trig = win_trig_reg;
    assign acq_run = acq_run_reg;
    assign free_run = free_run_reg;
    assign bw_limit = bw_limit_reg;
    assign trig_level = trig_level_reg;

    level_band_a: assert property (@(posedge clock) disable iff (!rst_n)
        (mode == MODE_AUTO_LEVEL && lvl_user_reg && $stable(lvl_lo) && $stable(lvl_hi))
        |=> (trig_level_reg >= $past(lvl_lo) && trig_level_reg <= $past(lvl_hi)))
        else $error("level outside band");
    free_run_a: assert property (@(posedge clock) disable iff (!rst_n)
        (acq_reg == ACQ_WAIT && tmo && !main_evt && mode != MODE_NORMAL)
        |=> (free_run_reg && acq_run_reg))
        else $error("no free run after timeout");
    normal_halt_a: assert property (@(posedge clock) disable iff (!rst_n)
        (acq_reg == ACQ_WAIT && tmo && !main_evt && mode == MODE_NORMAL)
        |=> !acq_run_reg ##1 (!acq_run_reg || $past(main_evt)))
        else $error("normal mode did not halt");
    ext_limits_a: assert property (@(posedge clock) disable iff (!rst_n)
        ext |-> (cpl <= CPL_DC_HFR && slope_pos && mode != MODE_AUTO_LEVEL)
        ##1 bw_limit_reg)
        else $error("extended settings not limited");
    bool_glitch_a: assert property (@(posedge clock) disable iff (!rst_n)
        (bool_evt && expr_reg.op != OP_TO) |-> func && $past(!func, GC))
        else $error("boolean edge not qualified");
    xor_func_a: assert property (@(posedge clock) disable iff (!rst_n)
        (expr_reg.op == OP_XOR) |-> (func == (src_a != src_b)))
        else $error("xor function wrong");
    win_follow_a: assert property (@(posedge clock) disable iff (!rst_n)
        bin |=> (win_trig_reg == main_trig_reg))
        else $error("window not following main");
    expr_reject_a: assert property (@(posedge clock) disable iff (!rst_n)
        (wr && hit_expr && new_bin && new_expr.lvl_qual)
        |=> (pslverr_reg && pready_reg && $stable(expr_reg)))
        else $error("bad expression accepted");
    short_pulse_a: assert property (@(posedge clock) disable iff (!rst_n)
        (expr_reg.qual == Q_LT1 && expr_reg.op != OP_TO && main_evt)
        |-> (fall && dur_reg < t1_reg))
        else $error("short pulse qualifier wrong");
    range_in_a: assert property (@(posedge clock) disable iff (!rst_n)
        (expr_reg.qual == Q_INSIDE && expr_reg.op != OP_TO && main_evt)
        |-> (dur_reg > t1_reg && dur_reg < t2_reg) ##1 main_trig_reg)
        else $error("inside range qualifier wrong");
    both_timed_a: assert property (@(posedge clock) disable iff (!rst_n)
        !((expr_reg.qual != Q_NONE) && (expr_reg.win_qual != Q_NONE)))
        else $error("duration on both triggers");
endmodule : stq_trigger_qualifier
`default_nettype wire

// [inc/stq_pkg.sv]
// Package of register map, codes and timing for the trigger qualifier
package stq_pkg;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_EXPR = 8'h04;
    localparam logic [7:0] OFS_TIME1 = 8'h08;
    localparam logic [7:0] OFS_TIME2 = 8'h0C;
    localparam logic [7:0] OFS_LEVEL = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam int CPL_LSB = 4;
    localparam int SLOPE_BIT = 8;
    localparam int ST_RUN_BIT = 0;
    localparam int ST_FREE_BIT = 1;
    localparam int ST_BW_BIT = 2;
    localparam int ST_LVL_LSB = 8;
    localparam logic [1:0] MODE_AUTO_LEVEL = 2'h0;
    localparam logic [1:0] MODE_AUTO = 2'h1;
    localparam logic [1:0] MODE_NORMAL = 2'h2;
    localparam logic [2:0] CPL_DC = 3'h0;
    localparam logic [2:0] CPL_DC_HFR = 3'h2;
    localparam logic [2:0] OP_NONE = 3'h0;
    localparam logic [2:0] OP_AND = 3'h1;
    localparam logic [2:0] OP_OR = 3'h2;
    localparam logic [2:0] OP_XOR = 3'h3;
    localparam logic [2:0] OP_TO = 3'h4;
    localparam logic [2:0] Q_NONE = 3'h0;
    localparam logic [2:0] Q_LT1 = 3'h1;
    localparam logic [2:0] Q_GT1 = 3'h2;
    localparam logic [2:0] Q_INSIDE = 3'h3;
    localparam logic [2:0] Q_OUTSIDE = 3'h4;
    localparam logic [31:0] CTRL_RST = 32'h0000_0101;
    localparam int CLK_NS = 10;
    localparam int GLITCH_NS = 2;
    localparam int GLITCH_CYC_RAW = (GLITCH_NS + CLK_NS - 1) / CLK_NS;
    localparam int GLITCH_CYC = (GLITCH_CYC_RAW < 1) ? 1 : GLITCH_CYC_RAW;
    localparam int LVL_LO_PCT = 20;
    localparam int LVL_HI_PCT = 80;
    localparam int PCT_FULL = 100;
    localparam int MID_SHIFT = 1;

    typedef struct packed {
        logic win_en;
        logic win_inv;
        logic [2:0] win_qual;
        logic lvl_qual;
        logic [2:0] qual;
        logic [2:0] op;
        logic inv_b;
        logic inv_a;
    } stq_expr_t;

    typedef enum logic [2:0] {
        ACQ_WAIT = 3'b001,
        ACQ_FREE = 3'b010,
        ACQ_HALT = 3'b100
    } stq_acq_t;
endpackage : stq_pkg

// [dv/stq_partner.sv]
// Comparator model: sources A and B against their own thresholds, window source against the A threshold
`timescale 1ns/100ps
`default_nettype none
module stq_partner #(
    parameter logic [7:0] LVL_A = 8'h80,
    parameter logic [7:0] LVL_B = 8'h40
) (
    input wire logic [7:0] volt_a,
    input wire logic [7:0] volt_b,
    input wire logic [7:0] volt_w,
    output logic cmp_a,
    output logic cmp_b,
    output logic cmp_w
);
    assign cmp_a = volt_a > LVL_A;
    assign cmp_b = volt_b > LVL_B;
    assign cmp_w = volt_w > LVL_A;
endmodule : stq_partner
`default_nettype wire

// [dv/stq_trigger_qualifier_bench.sv]
// Self-checking bench for the trigger qualifier
`timescale 1ns/100ps
`default_nettype none
module stq_trigger_qualifier_bench;
    import stq_pkg::*;
    logic clock = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = '0, sig_max = 8'hC8, sig_min = 8'h00;
    logic [7:0] volt_a = '0, volt_b = '0, volt_w = '0, trig_level;
    logic [31:0] pwdata = '0, prdata, rd, seed = 32'h6fe2_ff74;
    logic pready, pslverr, cmp_a, cmp_b, cmp_w, main_trig, win_trig;
    logic acq_run, free_run, bw_limit, er;
    int n_errors = 0, cmp_count = 0, trig_cnt = 0, win_cnt = 0, base, wbase, exp_n;
    stq_expr_t e;
    logic [2:0] ops [3] = '{OP_AND, OP_OR, OP_XOR};
    logic [2:0] quals [4] = '{Q_LT1, Q_GT1, Q_INSIDE, Q_OUTSIDE};
    logic [31:0] bad [4] = '{32'h0000_2004, 32'h0000_0104, 32'h0000_2010, 32'h0000_2220};
    bit pa, pb, fa, f_prev;

    always #5 clock = ~clock;
    always @(posedge clock) if (main_trig === 1'b1) trig_cnt <= trig_cnt + 1;
    always @(posedge clock) if (win_trig === 1'b1) win_cnt <= win_cnt + 1;

    stq_trigger_qualifier #(.AUTO_WAIT_CYC(20)) stq_trigger_qualifier_i (
        .clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cmp_a(cmp_a), .cmp_b(cmp_b), .cmp_w(cmp_w),
        .sig_max(sig_max), .sig_min(sig_min), .main_trig(main_trig),
        .win_trig(win_trig), .acq_run(acq_run), .free_run(free_run),
        .bw_limit(bw_limit), .trig_level(trig_level)
    );
    stq_partner stq_partner_i (
        .volt_a(volt_a), .volt_b(volt_b), .volt_w(volt_w),
        .cmp_a(cmp_a), .cmp_b(cmp_b), .cmp_w(cmp_w)
    );

    function automatic logic [31:0] stq_lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : stq_lfsr

    function automatic bit stq_func(input logic [2:0] op, input bit a, input bit b);
        case (op)
            OP_AND: return a & b;
            OP_OR: return a | b;
            default: return a ^ b;
        endcase
    endfunction : stq_func

    task automatic finish_test;
        $display("Comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // One APB transfer, waits for pready with a bound
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) check("pready", 0, 1);
    endtask : apb

    task automatic pulse_a(input int n);
        volt_a <= 8'hFF;
        repeat (n) @(posedge clock);
        volt_a <= 8'h00;
        repeat (12) @(posedge clock);
    endtask : pulse_a

    initial begin
        repeat (20000) @(posedge clock);
        n_errors++;
        finish_test();
    end

    initial begin
        repeat (4) @(posedge clock);
        check("acq_run in reset", acq_run, 0);
        rst_b <= 1'b1;
        repeat (4) @(posedge clock);
        apb(0, OFS_CTRL, 0);
        check("ctrl reset", rd, CTRL_RST);
        apb(1, OFS_CTRL, 0);
        repeat (4) @(posedge clock);
        check("midpoint level", trig_level, 8'd100);
        apb(1, OFS_LEVEL, 250);
        repeat (4) @(posedge clock);
        check("level high clamp", trig_level, 8'd160);
        apb(1, OFS_LEVEL, 10);
        apb(0, OFS_STATUS, 0);
        check("level low clamp", rd[15:8], 8'd40);
        repeat (30) @(posedge clock);
        check("auto level free run", free_run, 1);
        apb(1, OFS_CTRL, 32'h0000_0102);
        repeat (30) @(posedge clock);
        check("normal halt", {acq_run, free_run}, 0);
        pulse_a(3);
        check("normal resumes", acq_run, 1);
        repeat (30) @(posedge clock);
        check("normal halt after wait", acq_run, 0);
        apb(1, OFS_CTRL, 32'h0000_0101);
        repeat (30) @(posedge clock);
        check("auto free run", {acq_run, free_run}, 2'b11);
        pulse_a(3);
        check("auto triggered", free_run, 0);
        apb(1, OFS_CTRL, 32'h0000_0050);
        apb(1, OFS_EXPR, 32'h0000_0004);
        apb(0, OFS_CTRL, 0);
        check("coerced ctrl", rd, 32'h0000_0101);
        check("bandwidth limit", bw_limit, 1);
        apb(1, OFS_CTRL, 32'h0000_0122);
        apb(0, OFS_CTRL, 0);
        check("allowed ctrl kept", rd, 32'h0000_0122);
        apb(1, OFS_CTRL, 32'h0000_0070);
        apb(0, OFS_CTRL, 0);
        check("ctrl coerced again", rd, 32'h0000_0101);
        foreach (ops[i]) begin
            e = '0;
            e.op = ops[i];
            e.inv_a = seed[0];
            apb(1, OFS_EXPR, 32'(e));
            repeat (5) @(posedge clock);
            base = trig_cnt;
            wbase = win_cnt;
            exp_n = 0;
            f_prev = stq_func(e.op, e.inv_a, 0);
            for (int k = 0; k <= 40; k++) begin
                seed = stq_lfsr(seed);
                volt_a <= (k == 40) ? 8'h00 : seed[7:0];
                volt_b <= (k == 40) ? 8'h00 : seed[15:8];
                pa = ((k == 40) ? 8'h00 : seed[7:0]) > 8'h80;
                pb = ((k == 40) ? 8'h00 : seed[15:8]) > 8'h40;
                fa = stq_func(e.op, pa ^ e.inv_a, pb);
                if (fa && !f_prev) exp_n++;
                f_prev = fa;
                repeat (2) @(posedge clock);
            end
            repeat (4) @(posedge clock);
            check("boolean events", trig_cnt - base, exp_n);
            check("window follows main", win_cnt - wbase, exp_n);
        end
        apb(1, OFS_TIME1, 4);
        apb(1, OFS_TIME2, 7);
        foreach (quals[q]) begin
            e = '0;
            e.qual = quals[q];
            apb(1, OFS_EXPR, 32'(e));
            repeat (5) @(posedge clock);
            for (int n = 2; n <= 9; n++) begin
                base = trig_cnt;
                pulse_a(n);
                case (quals[q])
                    Q_LT1: exp_n = n < 4;
                    Q_GT1: exp_n = n > 4;
                    Q_INSIDE: exp_n = n > 4 && n < 7;
                    default: exp_n = n < 4 || n > 7;
                endcase
                check("duration trigger", trig_cnt - base, exp_n);
            end
        end
        foreach (bad[i]) begin
            apb(1, OFS_EXPR, bad[i]);
            check("expr refused", er, 1);
        end
        apb(0, OFS_EXPR, 0);
        check("expr kept", rd, 32'h0000_0080);
        apb(0, 8'h18, 0);
        check("unmapped read error", er, 1);
        check("unmapped read data", rd, 32'h0000_0000);
        apb(1, OFS_STATUS, 32'hFFFF_FFFF);
        check("status write", er, 1);
        // Window duration qualifier shorter than first limit
        apb(1, OFS_EXPR, 32'h0000_2200);
        for (int n = 2; n <= 5; n++) begin
            base = win_cnt;
            volt_w <= 8'hFF;
            repeat (n) @(posedge clock);
            volt_w <= 8'h00;
            repeat (12) @(posedge clock);
            check("window duration", win_cnt - base, n < 4);
        end
        // Interval from source A rise to source B rise, inside range
        apb(1, OFS_EXPR, 32'h0000_0070);
        for (int d = 2; d <= 9; d++) begin
            base = trig_cnt;
            volt_a <= 8'hFF;
            repeat (d) @(posedge clock);
            volt_b <= 8'hFF;
            repeat (2) @(posedge clock);
            volt_a <= 8'h00;
            volt_b <= 8'h00;
            repeat (12) @(posedge clock);
            check("interval trigger", trig_cnt - base, d > 4 && d < 7);
        end
        finish_test();
    end
endmodule : stq_trigger_qualifier_bench
`default_nettype wire
